// file: rtl/shc_consts.svh
// Constants for the host/client serial port: register map, fields, modes, timing
//
// Behaviour
// - Full byte goes to buffer, sets flags
// - Write during shifting discarded, collision flag set
// - Collision flag sticky; blocks writes until cleared
// - Buffer read clears buffer-full flag
// - Shift MSB first; only reached via buffer
// - Host starts shifting on buffer write
// - Receive-only host keeps shifting input
// - Host rate: /4, /16, /64, timer, reload
// - Polarity sets idle; edge bit picks launch
// - Edge bit set: data valid before edge
// - Client shifts on external clock; flags byte
// - Client keeps shifting while device sleeps
// - Overwrite enable accepts writes when unread
// - Mode code 0100 selects select-pin client
// - Select low enables shifting, drives output
// - Select high floats data output once synchronised, even mid-byte
// - Select high or disable zeroes bit counter
// - Host sleep freezes transfer, then resumes
// - Buffer write loads shift register too
// - Launch one edge, capture opposite edge
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH

// Register offsets
`define SHC_ADDR_STAT   3'h0
`define SHC_ADDR_CTRL1  3'h1
`define SHC_ADDR_CTRL3  3'h2
`define SHC_ADDR_BUF    3'h3
`define SHC_ADDR_RELOAD 3'h4
`define SHC_ADDR_IRQ    3'h5

// Field positions
`define SHC_STAT_PHASE  7
`define SHC_STAT_CKE    6
`define SHC_STAT_FULL   0
`define SHC_CTRL1_COLL  7
`define SHC_CTRL1_EN    5
`define SHC_CTRL1_POL   4
`define SHC_CTRL3_OVWR  4
`define SHC_CTRL3_SDOFF 0
`define SHC_IRQ_FLAG    0

// Mode codes in the low nibble of control register 1
`define SHC_MODE_DIV4   4'h0
`define SHC_MODE_DIV16  4'h1
`define SHC_MODE_DIV64  4'h2
`define SHC_MODE_TMR    4'h3
`define SHC_MODE_CL_SS  4'h4
`define SHC_MODE_CL     4'h5
`define SHC_MODE_RELOAD 4'hA

// Half bit periods in clocks for the fixed host rates
`define SHC_HALF_DIV4   9'h002
`define SHC_HALF_DIV16  9'h008
`define SHC_HALF_DIV64  9'h020

// Transfer geometry
`define SHC_LAST_BIT    4'h7
`define SHC_LAST_HALF   5'h0F
`define SHC_RST_BYTE    8'h00

`endif

// file: rtl/shc_pkg.sv
// Types used by the serial port top module
package shc_pkg;

  // Host sequencer states
  typedef enum logic [0:0] {
    SHC_IDLE  = 1'b0,
    SHC_SHIFT = 1'b1
  } shc_state_t;

  // Complete state of the port top module
  typedef struct packed {
    shc_state_t  st;       // Host sequencer
    logic        sck;      // Clock pin level
    logic        sck_oe;   // Clock pin drive
    logic        sdo;      // Data pin level
    logic        sdo_oe;   // Data pin drive
    logic [7:0]  sr;       // Shift register
    logic [7:0]  xbuf;     // Transfer buffer
    logic        buffer_full_flag;        // Buffer full
    logic        irq;                     // Port interrupt flag
    logic        write_collision_flag;    // Write collision
    logic [3:0]  cnt;      // Bit counter
    logic [4:0]  half;     // Host half periods done
    logic        en;       // Port enable
    logic        clock_idle_polarity;     // Clock idle level
    logic        cke;                     // Launch on trailing edge
    logic        input_sample_phase;      // Sample phase bit
    logic [3:0]  mode;                    // Mode code
    logic        buffer_overwrite_enable; // Buffer overwrite enable
    logic        sdo_off;  // Receive-only host
    logic [7:0]  add;      // Rate reload value
    logic [7:0]  rdata;    // Read data
    logic        sck_q;    // Previous synced client clock
  } shc_port_t;

endpackage

// file: rtl/shc_sync2.sv
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module shc_sync2 #(
  parameter int WIDTH = 3  // Levels carried
) (
  input  wire logic             ref_clk, // System clock
  input  wire logic             rst_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] d,       // Asynchronous levels
  output logic      [WIDTH-1:0] q        // Synchronised levels
);
  // Stage one feeds only stage two
  typedef struct packed {
    logic [WIDTH-1:0] s1; // First stage
    logic [WIDTH-1:0] s2; // Second stage
  } shc_sync_t;

  shc_sync_t sync_reg;  // Present state
  shc_sync_t sync_next; // Next state

  generate
    if (WIDTH < 1) begin : g_chk
      $error("shc_sync2: WIDTH must be at least 1");
    end
  endgenerate

  // Shift along the chain
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;
endmodule

// file: rtl/shc_rate_div.sv
`include "shc_consts.svh"
// Host bit-rate generator: one tick per half bit period
`timescale 1ns/1ps
module shc_rate_div #(
  parameter int CNT_W = 9  // Counter width
) (
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic [3:0] mode,    // Rate mode code
  input  wire logic [7:0] reload,  // Reload value
  input  wire logic       run,     // Count enable
  input  wire logic       clr,     // Restart the period
  input  wire logic       tmr_tick,// Timer-two output pulse
  output logic            tick     // Half period elapsed
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // Clocks into the half period
  } shc_div_t;

  shc_div_t   div_reg;  // Present state
  shc_div_t   div_next; // Next state
  logic [8:0] half;     // Half period length

  generate
    if (CNT_W < 9) begin : g_chk
      $error("shc_rate_div: CNT_W must be at least 9");
    end
  endgenerate

  // host rate choice
  // Half period select; reload rate is 2*(n+1) clocks per half
  always_comb begin
    if (mode == `SHC_MODE_DIV16) begin
      half = `SHC_HALF_DIV16;
    end else if (mode == `SHC_MODE_DIV64) begin
      half = `SHC_HALF_DIV64;
    end else if (mode == `SHC_MODE_RELOAD) begin
      half = {reload, 1'b0} + 9'h002;
    end else begin
      half = `SHC_HALF_DIV4;
    end
  end

  // Counter holds while paused, so a frozen transfer resumes mid-period
  always_comb begin
    div_next = div_reg;
    tick     = 1'b0;
    if (clr) begin
      div_next.cnt = '0;
    end else if (run && mode == `SHC_MODE_TMR) begin
      tick = tmr_tick;
    end else if (run) begin
      if (div_reg.cnt == CNT_W'(half - 9'h001)) begin
        tick         = 1'b1;
        div_next.cnt = '0;
      end else begin
        div_next.cnt = div_reg.cnt + 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule

// file: rtl/shc_spi_port.sv
`include "shc_consts.svh"
// Byte-wide serial port, host or client, with its register file
`timescale 1ns/1ps
module shc_spi_port (
  input  wire logic       ref_clk,   // System clock, 100 MHz
  input  wire logic       rst_n,     // Async reset, active low
  input  wire logic [2:0] addr,      // Register address
  input  wire logic [7:0] wdata,     // Write data
  input  wire logic       wr,        // Write strobe
  input  wire logic       rd,        // Read strobe
  output logic      [7:0] rdata,     // Read data, cycle after rd
  input  wire logic       sleep_req, // Device asleep
  input  wire logic       tmr_tick,  // Timer-two output pulse
  input  wire logic       sck_in,    // Clock pin input
  output logic            sck_out,   // Clock pin output
  output logic            sck_oe,    // Clock pin drive enable
  input  wire logic       sdi,       // Data input pin
  output logic            sdo_out,   // Data output pin
  output logic            sdo_oe,    // Data output drive enable
  input  wire logic       ss_n,      // Client select, active low
  output logic            irq_flag   // Port interrupt flag
);
  shc_pkg::shc_port_t r;      // Present state (state_reg)
  shc_pkg::shc_port_t n;      // Next state (state_next)
  logic [2:0]         syn;    // Synced sck, ss_n, sdi
  logic               rate_tick; // Host half period tick
  logic               host;   // Host mode selected
  logic               ss_ctl; // Select-pin control on
  logic               cl_on;  // Client selected and enabled
  logic               lead;   // Idle-to-active edge
  logic               trail;  // Active-to-idle edge
  logic               cap;    // Capture edge
  logic               launch; // Launch edge
  logic               done;   // Byte complete
  logic               done_h; // Host byte complete
  logic               busy;   // Byte in flight
  logic               buf_wr; // Buffer write strobe
  logic               din;    // Data bit being captured
  logic               port_rst; // Bit counter reset

  // Client pins cross into the system clock before use
  shc_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({sck_in, ss_n, sdi}),
    .q       (syn)
  );

  // sleep stops the rate ticks
  // Host bit clock source; paused while asleep
  shc_rate_div #(
    .CNT_W (9)
  ) u_rate (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .mode     (r.mode),
    .reload   (r.add),
    .run      (r.st == shc_pkg::SHC_SHIFT && !sleep_req),
    .clr      (r.st == shc_pkg::SHC_IDLE),
    .tmr_tick (tmr_tick),
    .tick     (rate_tick)
  );

  // Mode decode
  always_comb begin
    host   = (r.mode != `SHC_MODE_CL_SS) && (r.mode != `SHC_MODE_CL);
    ss_ctl = (r.mode == `SHC_MODE_CL_SS);
    cl_on  = r.en && !host && !(ss_ctl && syn[1]);
    port_rst = !r.en || (ss_ctl && syn[1]);
    buf_wr = wr && addr == `SHC_ADDR_BUF;
  end

  // Next-state logic for the whole port
  always_comb begin
    n       = r;
    n.rdata = `SHC_RST_BYTE;
    lead    = 1'b0;
    trail   = 1'b0;
    done_h  = 1'b0;
    n.sck_q = syn[2];

    // Register writes other than the buffer
    if (wr && addr == `SHC_ADDR_STAT) begin
      n.input_sample_phase = wdata[`SHC_STAT_PHASE];
      n.cke                = wdata[`SHC_STAT_CKE];
    end else if (wr && addr == `SHC_ADDR_CTRL1) begin
      n.write_collision_flag = r.write_collision_flag & wdata[`SHC_CTRL1_COLL];
      n.en                   = wdata[`SHC_CTRL1_EN];
      n.clock_idle_polarity  = wdata[`SHC_CTRL1_POL];
      n.mode                 = wdata[3:0];
    end else if (wr && addr == `SHC_ADDR_CTRL3) begin
      n.buffer_overwrite_enable = wdata[`SHC_CTRL3_OVWR];
      n.sdo_off = wdata[`SHC_CTRL3_SDOFF];
    end else if (wr && addr == `SHC_ADDR_RELOAD) begin
      n.add = wdata;
    end else if (wr && addr == `SHC_ADDR_IRQ && wdata[`SHC_IRQ_FLAG]) begin
      n.irq = 1'b0;
    end

    // Register reads; the shift register itself has no address
    if (rd) begin
      if (addr == `SHC_ADDR_STAT) begin
        n.rdata = {r.input_sample_phase, r.cke, 5'h00, r.buffer_full_flag};
      end else if (addr == `SHC_ADDR_CTRL1) begin
        n.rdata = {r.write_collision_flag, 1'b0, r.en, r.clock_idle_polarity, r.mode};
      end else if (addr == `SHC_ADDR_CTRL3) begin
        n.rdata = {3'h0, r.buffer_overwrite_enable, 3'h0, r.sdo_off};
      end else if (addr == `SHC_ADDR_BUF) begin
        n.rdata = r.xbuf;
        n.buffer_full_flag = 1'b0;
      end else if (addr == `SHC_ADDR_RELOAD) begin
        n.rdata = r.add;
      end else if (addr == `SHC_ADDR_IRQ) begin
        n.rdata = {7'h00, r.irq};
      end else begin
        n.rdata = `SHC_RST_BYTE;
      end
    end

    // Host clock generator; each tick is one edge
    case (r.st)
      shc_pkg::SHC_IDLE: begin
        n.sck = r.clock_idle_polarity;
      end
      shc_pkg::SHC_SHIFT: begin
        if (rate_tick) begin
          n.sck  = ~r.sck;
          lead   = (r.sck == r.clock_idle_polarity);
          trail  = !lead;
          n.half = r.half + 1'b1;
          if (r.half == `SHC_LAST_HALF) begin
            done_h = 1'b1;
            n.st   = shc_pkg::SHC_IDLE;
          end
        end
      end
      default: begin
        n.st = shc_pkg::SHC_IDLE;
      end
    endcase

    // client edges come only from the pin
    // sleep_req is not looked at here, so a client byte completes asleep
    if (cl_on) begin
      lead  = (syn[2] != r.clock_idle_polarity) && (r.sck_q == r.clock_idle_polarity);
      trail = (syn[2] == r.clock_idle_polarity) && (r.sck_q != r.clock_idle_polarity);
    end

    cap    = r.cke ? lead : trail;
    launch = r.cke ? trail : lead;
    // host samples the pin even when not driving output
    din    = host ? sdi : syn[0];

    // shift towards the MSB, output from bit 7
    if (launch) begin
      n.sdo = r.sr[7];
    end
    if (cap) begin
      n.sr  = {r.sr[6:0], din};
      n.cnt = r.cnt + 1'b1;
    end

    // Byte boundary; client completes on eighth capture
    done = host ? done_h : (cap && r.cnt == `SHC_LAST_BIT);
    if (done) begin
      n.xbuf = n.sr;
      n.buffer_full_flag = 1'b1;
      n.irq  = 1'b1;
      n.cnt  = 4'h0;
    end

    if (port_rst) begin
      n.cnt = 4'h0;
      if (!r.en) begin
        n.st = shc_pkg::SHC_IDLE;
      end
    end

    // A capture this cycle also counts as in flight
    busy = host ? (r.st == shc_pkg::SHC_SHIFT) : (r.cnt != 4'h0 || cap);

    // Buffer write; collision and unread-data cases drop it
    if (buf_wr) begin
      if (busy) begin
        n.write_collision_flag = 1'b1;
      end else if (r.write_collision_flag) begin
        n.write_collision_flag = 1'b1;
      end else if (r.buffer_full_flag && !r.buffer_overwrite_enable) begin
        // unread byte blocks unless overwrite on
        n.xbuf = r.xbuf;
      end else begin
        // buffer and shift register load together
        n.xbuf = wdata;
        n.sr   = wdata;
        // MSB on the pin before the first edge
        n.sdo  = wdata[7];
        if (host && r.en) begin
          n.st   = shc_pkg::SHC_SHIFT;
          n.half = 5'h00;
        end
      end
    end

    // Pin drivers; select high floats output
    n.sck_oe = n.en && host;
    n.sdo_oe = host ? (n.en && !n.sdo_off) : cl_on;
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state flops
  assign rdata    = r.rdata;
  assign sck_out  = r.sck;
  assign sck_oe   = r.sck_oe;
  assign sdo_out  = r.sdo;
  assign sdo_oe   = r.sdo_oe;
  assign irq_flag = r.irq;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_DONE_FLAGS: assert property (done |=> r.buffer_full_flag && r.irq)
    else $error("byte done without flags");
  // A byte that lands in the same cycle legally replaces the buffer
  AST_WR_COLLIDE: assert property (buf_wr && busy && !done
    |=> r.write_collision_flag && r.xbuf == $past(r.xbuf))
    else $error("busy write not discarded");
  AST_COLL_STICKY: assert property (r.write_collision_flag && !(wr && addr == `SHC_ADDR_CTRL1)
    |=> r.write_collision_flag)
    else $error("collision flag lost");
  AST_READ_CLR: assert property (rd && addr == `SHC_ADDR_BUF && !done |=> !r.buffer_full_flag)
    else $error("buffer read kept full flag");
  AST_HOST_START: assert property (buf_wr && host && r.en && !busy && !r.write_collision_flag
    && (!r.buffer_full_flag || r.buffer_overwrite_enable)
    |=> r.st == shc_pkg::SHC_SHIFT && r.sr == $past(wdata) && r.sdo == $past(wdata[7]))
    else $error("host did not start");
  AST_SS_FLOAT: assert property (r.en && ss_ctl && syn[1] |=> !r.sdo_oe && r.cnt == 4'h0)
    else $error("select high still driving");
  AST_DIS_RST: assert property (!r.en |=> r.cnt == 4'h0 && r.st == shc_pkg::SHC_IDLE)
    else $error("disable did not reset");
  AST_SLEEP_HOLD: assert property (r.st == shc_pkg::SHC_SHIFT && sleep_req |=> $stable(r.sck) && $stable(r.half))
    else $error("host moved while asleep");
  AST_IRQ_STICKY: assert property (r.irq && !(wr && addr == `SHC_ADDR_IRQ) |=> r.irq)
    else $error("interrupt flag lost");
  AST_HOST_LEN: assert property (r.st == shc_pkg::SHC_SHIFT && rate_tick && r.half == `SHC_LAST_HALF
    |=> r.st == shc_pkg::SHC_IDLE && r.sck == r.clock_idle_polarity)
    else $error("host byte length wrong");

  COV_HOST_BYTE: cover property (done && host);
  COV_CLIENT_BYTE: cover property (done && !host);
  COV_COLLIDE: cover property (buf_wr && busy);
endmodule

// file: tb/shc_spi_partner.sv
// Far-side model: SPI client facing a host port, SPI host facing a client port
`timescale 1ns/1ps
module shc_spi_partner #(
  parameter int HALF = 6  // Host-role half period in clocks
) (
  input  wire logic ref_clk, // System clock
  input  wire logic role,    // High: act as host
  input  wire logic cpol,    // Clock idle level
  input  wire logic cke,     // Launch on return to idle
  input  wire logic sel_n,   // Client role selected, active low
  input  wire logic sck_pin, // Clock wire level
  input  wire logic sdo_w,   // Port data wire level
  output logic      sck_drv, // Clock in host role
  output logic      sdi,     // Data toward the port
  output logic      ss_n     // Select toward the port
);
  logic [7:0] tx_sr  = 8'h00; // Outgoing byte
  logic [7:0] rx_sr  = 8'h00; // Incoming byte
  logic       sck_q  = 1'b0;  // Clock wire one cycle ago
  logic       hold   = 1'b1;  // MSB already shown, skip first launch
  logic       idle_t = 1'b0;  // Filler for a released line
  logic       h_sdi  = 1'b0;  // Host-role data bit
  logic       launch;         // Current edge launches data

  initial sck_drv = 1'b0;
  initial ss_n = 1'b1;

  // Edge leaving idle launches unless the edge bit is set
  assign launch = (sck_pin != cpol) ^ cke;

  // shift out on launch edge, sample on the opposite one
  always @(posedge ref_clk) begin
    idle_t <= ~idle_t;
    sck_q  <= sck_pin;
    if (!role && !sel_n && sck_pin != sck_q) begin
      if (!launch)
        rx_sr <= {rx_sr[6:0], sdo_w};
      else if (hold)
        hold <= 1'b0;
      else
        tx_sr <= {tx_sr[6:0], 1'b0};
    end
  end

  // Released line toggles so a stale level never passes for data
  assign sdi = (role ? ss_n : sel_n) ? idle_t : (role ? h_sdi : tx_sr[7]);

  // Preload the client-role byte
  task automatic load(input logic [7:0] b);
    tx_sr = b;
    hold  = ~cke;
  endtask

  // clock stops and client is released after the bits asked for
  task automatic hxfer(input logic [7:0] b, input int nbits, output logic [7:0] got);
    got = 8'h00;
    @(posedge ref_clk);
    ss_n <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    for (int i = 7; i > 7 - nbits; i--) begin
      sck_drv <= ~cpol;
      h_sdi   <= b[i];
      repeat (HALF) @(posedge ref_clk);
      sck_drv <= cpol;
      got[i]  = sdo_w;
      repeat (HALF) @(posedge ref_clk);
    end
    ss_n <= 1'b1;
  endtask
endmodule

// file: tb/shc_spi_port_tb.sv
// Self-checking bench for the host/client serial port
`timescale 1ns/1ps
`include "shc_consts.svh"
module shc_spi_port_tb;
  logic       ref_clk   = 1'b0; // System clock
  logic       rst_n     = 1'b0; // Reset, active low
  logic [2:0] addr      = 3'h0; // Register address
  logic [7:0] wdata     = 8'h00;// Write data
  logic       wr        = 1'b0; // Write strobe
  logic       rd        = 1'b0; // Read strobe
  logic       sleep_req = 1'b0; // Device asleep
  logic       tmr_tick  = 1'b0; // Timer pulse
  logic [2:0] tcnt      = 3'h0; // Timer pulse spacing
  logic       p_role    = 1'b0; // Partner acts as host
  logic       p_cpol    = 1'b0; // Partner idle level
  logic       p_cke     = 1'b0; // Partner edge choice
  logic       p_sel_n   = 1'b1; // Partner selected as client
  logic [7:0] rdata;            // Read data
  logic       sck_out, sck_oe, sdo_out, sdo_oe, irq_flag; // Port outputs
  logic       sdi, ss_n, p_sck; // Partner outputs
  logic       sck_pin, sdo_w;   // Wire levels
  logic [7:0] d, rx;            // Read and received bytes
  logic       moved;            // Clock moved while asleep
  int         err_count       = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  logic [3:0] modes  [5] = '{`SHC_MODE_DIV4, `SHC_MODE_DIV16, `SHC_MODE_DIV64, `SHC_MODE_TMR, `SHC_MODE_RELOAD};
  logic [7:0] halves [5] = '{8'h02, 8'h08, 8'h20, 8'h05, 8'h06};

  // Clock wire from whoever drives it; released data line shows its inverse
  assign sck_pin = sck_oe ? sck_out : p_sck;
  assign sdo_w   = sdo_oe ? sdo_out : ~sdo_out;

  always #5 ref_clk = ~ref_clk;

  // Timer pulse every fifth clock, and hang guard
  always @(posedge ref_clk) begin
    tcnt     <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    tmr_tick <= (tcnt == 3'h4);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  shc_spi_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sleep_req(sleep_req), .tmr_tick(tmr_tick), .sck_in(sck_pin), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n(ss_n), .irq_flag(irq_flag));

  shc_spi_partner p_u (.ref_clk(ref_clk), .role(p_role), .cpol(p_cpol), .cke(p_cke), .sel_n(p_sel_n),
    .sck_pin(sck_pin), .sdo_w(sdo_w), .sck_drv(p_sck), .sdi(sdi), .ss_n(ss_n));

  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_irq;
    repeat (3000) if (irq_flag !== 1'b1) @(posedge ref_clk);
    #1 chk({7'h00, irq_flag}, 8'h01);
  endtask

  // One host byte: rate, lead bit, drive, flags and both data directions
  task automatic host_byte(input logic [7:0] tx, input logic [7:0] ptx, input logic [7:0] half,
                           input logic tx_on);
    int h;
    p_u.load(ptx);
    wr_reg(`SHC_ADDR_BUF, tx);
    h = 0;
    #1;
    while (sck_out === p_cpol && h < 400) begin @(posedge ref_clk); #1; h++; end
    if (p_cke) chk({7'h00, sdo_out}, {7'h00, tx[7]});
    h = 0;
    while (sck_out !== p_cpol && h < 400) begin @(posedge ref_clk); #1; h++; end
    chk(8'(h), half);
    chk({6'h00, sck_oe, sdo_oe}, {6'h00, 1'b1, tx_on});
    wait_irq();
    rd_reg(`SHC_ADDR_STAT, d);
    chk(d & 8'h01, 8'h01);
    rd_reg(`SHC_ADDR_BUF, d);
    chk(d, ptx);
    if (tx_on) chk(p_u.rx_sr, tx);
    rd_reg(`SHC_ADDR_STAT, d);
    chk(d & 8'h01, 8'h00);
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    @(posedge ref_clk);
    #1 chk({7'h00, irq_flag}, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(`SHC_ADDR_CTRL1, d);
    chk(d, 8'h00);
    rd_reg(3'h7, d);
    chk(d, 8'h00);
    wr_reg(`SHC_ADDR_RELOAD, 8'h02);
    p_sel_n <= 1'b0;
    for (int m = 0; m < 5; m++) begin
      wr_reg(`SHC_ADDR_CTRL1, {4'h2, modes[m]});
      host_byte({4'hA, 4'(m)}, {4'h5, ~4'(m)}, halves[m], 1'b1);
    end
    // Write during shifting, then while the collision flag stays set
    p_u.load(8'h3C);
    wr_reg(`SHC_ADDR_BUF, 8'h96);
    wr_reg(`SHC_ADDR_BUF, 8'h11);
    rd_reg(`SHC_ADDR_CTRL1, d);
    chk(d & 8'h80, 8'h80);
    wait_irq();
    rd_reg(`SHC_ADDR_BUF, d);
    chk(p_u.rx_sr, 8'h96);
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    wr_reg(`SHC_ADDR_BUF, 8'h22);
    repeat (40) @(posedge ref_clk);
    #1 chk({7'h00, irq_flag}, 8'h00);
    wr_reg(`SHC_ADDR_CTRL1, 8'h20);
    host_byte(8'h5A, 8'hC3, 8'h02, 1'b1);
    // Unread byte blocks the next write until overwrite is enabled
    p_u.load(8'h0F);
    wr_reg(`SHC_ADDR_BUF, 8'hE1);
    wait_irq();
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    wr_reg(`SHC_ADDR_BUF, 8'h77);
    repeat (40) @(posedge ref_clk);
    #1 chk({7'h00, irq_flag}, 8'h00);
    wr_reg(`SHC_ADDR_CTRL3, 8'h10);
    host_byte(8'h77, 8'hF0, 8'h02, 1'b1);
    // Idle high, launch on return to idle
    wr_reg(`SHC_ADDR_CTRL3, 8'h00);
    wr_reg(`SHC_ADDR_STAT, 8'h40);
    p_cke  <= 1'b1;
    p_cpol <= 1'b1;
    wr_reg(`SHC_ADDR_CTRL1, 8'h31);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, sck_out}, 8'h01);
    host_byte(8'hB4, 8'h2D, 8'h08, 1'b1);
    // Receive-only host
    wr_reg(`SHC_ADDR_STAT, 8'h00);
    p_cke  <= 1'b0;
    p_cpol <= 1'b0;
    wr_reg(`SHC_ADDR_CTRL1, 8'h21);
    wr_reg(`SHC_ADDR_CTRL3, 8'h01);
    host_byte(8'hFF, 8'h9D, 8'h08, 1'b0);
    wr_reg(`SHC_ADDR_CTRL3, 8'h00);
    // Host transfer frozen by sleep, then finished
    p_u.load(8'h4B);
    wr_reg(`SHC_ADDR_BUF, 8'hD2);
    repeat (20) @(posedge ref_clk);
    sleep_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 moved = 1'b0;
    rx[0] = sck_out;
    repeat (60) begin @(posedge ref_clk); #1 if (sck_out !== rx[0]) moved = 1'b1; end
    chk({7'h00, moved | irq_flag}, 8'h00);
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    wait_irq();
    rd_reg(`SHC_ADDR_BUF, d);
    chk(d, 8'h4B);
    chk(p_u.rx_sr, 8'hD2);
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    // edge and sample phase bits stay clear; select-pin client, shifting asleep
    wr_reg(`SHC_ADDR_CTRL1, 8'h00);
    p_sel_n <= 1'b1;
    p_role  <= 1'b1;
    wr_reg(`SHC_ADDR_CTRL1, 8'h24);
    wr_reg(`SHC_ADDR_BUF, 8'hA7);
    sleep_req <= 1'b1;
    p_u.hxfer(8'h3E, 8, rx);
    chk(rx, 8'hA7);
    wait_irq();
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    rd_reg(`SHC_ADDR_BUF, d);
    chk(d, 8'h3E);
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    p_u.hxfer(8'h55, 3, rx);
    repeat (4) @(posedge ref_clk);
    #1 chk({5'h00, sck_oe, sdo_oe, irq_flag}, 8'h00);
    p_u.hxfer(8'hC9, 8, rx);
    wait_irq();
    rd_reg(`SHC_ADDR_BUF, d);
    chk(d, 8'hC9);
    wr_reg(`SHC_ADDR_IRQ, 8'h01);
    // Client without select: disabling the port realigns the bit count
    wr_reg(`SHC_ADDR_CTRL1, 8'h25);
    p_u.hxfer(8'h12, 3, rx);
    wr_reg(`SHC_ADDR_CTRL1, 8'h05);
    wr_reg(`SHC_ADDR_CTRL1, 8'h25);
    p_u.hxfer(8'h81, 8, rx);
    wait_irq();
    rd_reg(`SHC_ADDR_BUF, d);
    chk(d, 8'h81);
    stop_test();
  end
endmodule
